// ==== hw/pmsc_pkg.sv ====
package pmsc_pkg;

  // ----------------------------------------------------------------
  // geometry
  // ----------------------------------------------------------------
  localparam int NCH = 8;
  localparam int NVM_DEPTH = 32;
  localparam int WORD_W = 16;

  // ----------------------------------------------------------------
  // command codes
  // ----------------------------------------------------------------
  localparam logic [7:0] CMD_COMM_STATUS   = 8'h7e;
  localparam logic [7:0] CMD_VENDOR_STATUS = 8'h80;
  localparam logic [7:0] CMD_VIN           = 8'h88;
  localparam logic [7:0] CMD_VOUT          = 8'h8b;
  localparam logic [7:0] CMD_TEMP          = 8'h8d;
  localparam logic [7:0] CMD_REVISION      = 8'h98;
  localparam logic [7:0] CMD_TOOL_USER_A   = 8'hb0;
  localparam logic [7:0] CMD_TOOL_USER_B   = 8'hb1;
  localparam logic [7:0] CMD_OEM_USER      = 8'hb2;
  localparam logic [7:0] CMD_SCRATCH_PAGED = 8'hb3;
  localparam logic [7:0] CMD_SCRATCH_GLOB  = 8'hb4;
  localparam logic [7:0] CMD_RSVD_A        = 8'hb5;
  localparam logic [7:0] CMD_VENDOR_INFO   = 8'hb6;
  localparam logic [7:0] CMD_EXTRA_STATUS  = 8'hb7;
  localparam logic [7:0] CMD_RSVD_B        = 8'hbc;
  localparam logic [7:0] CMD_NVM_UNLOCK    = 8'hbd;
  localparam logic [7:0] CMD_NVM_ERASE     = 8'hbe;
  localparam logic [7:0] CMD_NVM_DATA      = 8'hbf;
  localparam logic [7:0] CMD_ALT_COMMAND   = 8'hc0;
  localparam logic [7:0] CMD_ALT_DATA0     = 8'hc1;
  localparam logic [7:0] CMD_ALT_DATA1     = 8'hc2;
  localparam logic [7:0] CMD_TELEMETRY     = 8'hcf;
  localparam logic [7:0] CMD_CH_CONFIG     = 8'hd0;
  localparam logic [7:0] CMD_GLOB_CONFIG   = 8'hd1;
  localparam logic [7:0] CMD_FAULT_PROP0   = 8'hd2;
  localparam logic [7:0] CMD_FAULT_PROP1   = 8'hd3;
  localparam logic [7:0] CMD_PG_MAPPING    = 8'hd4;

  // ----------------------------------------------------------------
  // reset values and fixed answers
  // ----------------------------------------------------------------
  localparam logic [7:0]  REVISION_VALUE  = 8'h11;
  localparam logic [15:0] CH_CONFIG_RST   = 16'h0080;
  localparam logic [15:0] GLOB_CONFIG_RST = 16'h1c7b;
  localparam logic [7:0]  FAULT_PROP_RST  = 8'h00;
  localparam logic [15:0] PG_MAPPING_RST  = 16'h0000;
  localparam logic [15:0] SCRATCH_RST     = 16'h0000;
  localparam logic [15:0] USER_WORD_RST   = 16'h0000;
  localparam logic [7:0]  PAGE_GLOBAL     = 8'hff;
  localparam logic [7:0]  TLM_BYTE_COUNT  = 8'h10;

  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int CML_BAD_CMD   = 7;
  localparam int CML_BAD_DATA  = 6;
  localparam int CML_MEM_FAULT = 4;
  localparam int PG_WDOG_BIT   = 8;
  localparam int PROP_LOW_PIN  = 0;
  localparam int PROP_HIGH_PIN = 1;

  // ----------------------------------------------------------------
  // user nonvolatile memory
  // ----------------------------------------------------------------
  localparam logic [7:0]  NVM_UNLOCK_KEY = 8'h2b;
  localparam logic [15:0] NVM_ERASED     = 16'hffff;

endpackage

// ==== hw/pmsc_nvm_store.sv ====
`timescale 1ns/100ps
module pmsc_nvm_store
  import pmsc_pkg::*;
#(
  parameter int DEPTH = pmsc_pkg::NVM_DEPTH,
  parameter int WIDTH = pmsc_pkg::WORD_W
)
(
  input  wire logic             clk_i,
  input  wire logic             arst_n_i,
  input  wire logic             unlock_wr_i,
  input  wire logic [7:0]       unlock_data_i,
  input  wire logic             erase_wr_i,
  input  wire logic             data_wr_i,
  input  wire logic             data_rd_i,
  input  wire logic [WIDTH-1:0] wdata_i,
  output logic      [WIDTH-1:0] rdata_o,
  output logic                  unlocked_o,
  output logic                  refused_o
);

  localparam int PW = $clog2(DEPTH);

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [PW-1:0]               ptr;
    logic                        unlocked;
  } pmsc_nvm_state_t;

  pmsc_nvm_state_t s;
  pmsc_nvm_state_t next_s;

  // ----------------------------------------------------------------
  // unlock, erase and sequential word access
  // ----------------------------------------------------------------
  always_comb
  begin
    next_s = s;
    refused_o = 1'b0;
    if (unlock_wr_i)
    begin
      next_s.unlocked = (unlock_data_i == NVM_UNLOCK_KEY); // R7
      next_s.ptr = '0;
    end
    if ((erase_wr_i || data_wr_i || data_rd_i) && !s.unlocked)
    begin
      refused_o = 1'b1; // R7
    end
    else if (erase_wr_i)
    begin
      next_s.mem = {DEPTH{NVM_ERASED}}; // R8
      next_s.ptr = '0;
    end
    else if (data_wr_i || data_rd_i)
    begin
      if (data_wr_i)
      begin
        next_s.mem[s.ptr] = wdata_i;
      end
      next_s.ptr = s.ptr + 1'b1; // R9
    end
  end

  // state register
  always_ff @(posedge clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      s <= '{mem: {DEPTH{NVM_ERASED}}, ptr: '0, unlocked: 1'b0};
    end
    else
    begin
      s <= next_s;
    end
  end

  assign rdata_o = data_rd_i && s.unlocked ? s.mem[s.ptr] : '0;
  assign unlocked_o = s.unlocked;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  sequence locked_access_s;
    !s.unlocked && (data_wr_i || erase_wr_i) && !unlock_wr_i;
  endsequence

  chk_locked_refuse: assert property (@(posedge clk_i) disable iff (!arst_n_i) // R7
    locked_access_s |-> refused_o ##1 (s.mem == $past(s.mem)))
    else $error("locked memory was altered");

  chk_erase_fill: assert property (@(posedge clk_i) disable iff (!arst_n_i) // R8
    (erase_wr_i && s.unlocked && !unlock_wr_i) |=> (s.mem[0] == NVM_ERASED) && (s.ptr == '0))
    else $error("erase did not initialise memory");

  chk_seq_advance: assert property (@(posedge clk_i) disable iff (!arst_n_i) // R9
    ((data_wr_i || data_rd_i) && s.unlocked && !unlock_wr_i && !erase_wr_i)
      |=> s.ptr == $past(s.ptr) + 1'b1)
    else $error("sequential pointer did not advance");

endmodule

// ==== hw/pmsc_cmd_map.sv ====
`timescale 1ns/100ps
// How it works
// R1 - status byte 0x7E reports communication and memory faults, unpaged, read only.
// R2 - byte 0x80 returns vendor fault state of the selected channel.
// R3 - 0x88 input voltage and 0x8D die temperature are unpaged read-only words.
// R4 - 0x8B returns the selected channel's output voltage word.
// R5 - revision byte 0x98 always reads 0x11.
// R6 - word 0xB7 gives extra vendor fault state, one copy per page.
// R7 - erase and data access refused until the unlock command opens memory.
// R8 - erase command 0xBE initialises user memory for bulk programming.
// R9 - repeated 0xBF word accesses walk consecutive memory words.
// R10 - 0xC0 holds alternate command; 0xC1 and 0xC2 carry data for two hosts.
// R11 - block read 0xCF returns all channels' telemetry in one transaction.
// R12 - paged channel configuration word 0xD0 resets to 0x0080.
// R13 - shared global configuration word 0xD1 resets to 0x1C7B.
// R14 - paged byte 0xD2 routes faulted-off channels to fault pins 00 and 10.
// R15 - paged byte 0xD3 routes faulted-off channels to fault pins 01 and 11.
// R16 - word 0xD4 picks power-good channels and watchdog status for power-good pin.
// R17 - scratchpads 0xB3 paged and 0xB4 unpaged, read/write, reset zero.
// R18 - page 0xFF writes reach only channels enabled in global page mask.
// R19 - paged commands use the selected channel copy; unpaged ignore page.
// R20 - writes to read-only commands change nothing and flag a communication error.
module pmsc_cmd_map
  import pmsc_pkg::*;
(
  input  wire logic                                 clk_i,
  input  wire logic                                 arst_n_i,
  input  wire logic                                 req_i,
  input  wire logic                                 req_write_i,
  input  wire logic [7:0]                           req_code_i,
  input  wire logic [15:0]                          req_wdata_i,
  input  wire logic [4:0]                           blk_index_i,
  input  wire logic [7:0]                           page_i,
  input  wire logic [pmsc_pkg::NCH-1:0]             global_page_channel_mask_i,
  input  wire logic                                 clear_faults_i,
  input  wire logic [15:0]                          vin_reading_i,
  input  wire logic [15:0]                          temp_reading_i,
  input  wire logic [pmsc_pkg::NCH-1:0][15:0]       vout_reading_i,
  input  wire logic [pmsc_pkg::NCH-1:0][7:0]        vendor_status_i,
  input  wire logic [pmsc_pkg::NCH-1:0][15:0]       extra_status_i,
  input  wire logic [pmsc_pkg::NCH-1:0]             ch_faulted_off_i,
  input  wire logic [pmsc_pkg::NCH-1:0]             ch_power_good_i,
  input  wire logic                                 watchdog_ok_i,
  input  wire logic [3:0]                           shared_fault_pin_in_i,
  output logic      [3:0]                           shared_fault_pin_out_o,
  output logic      [3:0]                           shared_fault_pin_oe_o,
  output logic                                      power_good_output_o,
  output logic                                      rsp_valid_o,
  output logic      [15:0]                          rsp_data_o
);

  typedef struct packed {
    logic [7:0]             cml;
    logic [15:0]            alt_cmd;
    logic [2:0]             alt_ptr0;
    logic [2:0]             alt_ptr1;
    logic [NCH-1:0][15:0]   ch_cfg;
    logic [15:0]            glb_cfg;
    logic [NCH-1:0][7:0]    prop0;
    logic [NCH-1:0][7:0]    prop1;
    logic [15:0]            pg_map;
    logic [NCH-1:0][15:0]   scr_p;
    logic [15:0]            scr_g;
    logic [15:0]            user_a;
    logic [NCH-1:0][15:0]   user_b;
    logic [15:0]            user_c;
    logic                   rsp_valid;
    logic [15:0]            rsp_data;
    logic [3:0]             fpin_meta;
    logic [3:0]             fpin_sync;
    logic [3:0]             fpin_oe;
    logic                   pg_out;
  } pmsc_state_t;

  pmsc_state_t     s;
  pmsc_state_t     next_s;
  logic            alt_access;
  logic            alt_host1;
  logic [7:0]      eff_code;
  logic [2:0]      rd_ch;
  logic            page_ok;
  logic [NCH-1:0]  wr_hit;
  logic            wr_req;
  logic            rd_req;
  logic            nvm_unlock_wr;
  logic            nvm_erase_wr;
  logic            nvm_data_wr;
  logic            nvm_data_rd;
  logic [15:0]     nvm_rdata;
  logic            nvm_unlocked;
  logic            nvm_refused;

  // ----------------------------------------------------------------
  // command routing
  // ----------------------------------------------------------------
  // alternate data words act on the command held in the shared word
  assign alt_access = req_code_i == CMD_ALT_DATA0 || req_code_i == CMD_ALT_DATA1; // R10
  assign alt_host1  = req_code_i == CMD_ALT_DATA1;
  assign eff_code   = alt_access ? s.alt_cmd[7:0] : req_code_i;
  assign page_ok    = page_i < 8'(NCH) || page_i == PAGE_GLOBAL;
  assign rd_ch      = page_i < 8'(NCH) ? page_i[2:0] : 3'h0; // R19
  assign wr_req     = req_i && req_write_i;
  assign rd_req     = req_i && !req_write_i;

  // channels touched by a paged write
  always_comb
  begin
    for (int c = 0; c < NCH; c++)
    begin
      wr_hit[c] = (page_i == 8'(c)) || (page_i == PAGE_GLOBAL && global_page_channel_mask_i[c]); // R18 R19
    end
  end

  // user memory strobes
  assign nvm_unlock_wr = wr_req && eff_code == CMD_NVM_UNLOCK;
  assign nvm_erase_wr  = wr_req && eff_code == CMD_NVM_ERASE;
  assign nvm_data_wr   = wr_req && eff_code == CMD_NVM_DATA;
  assign nvm_data_rd   = rd_req && eff_code == CMD_NVM_DATA;

  pmsc_nvm_store #(
    .DEPTH (NVM_DEPTH),
    .WIDTH (WORD_W)
  ) u_nvm (
    .clk_i         (clk_i),
    .arst_n_i      (arst_n_i),
    .unlock_wr_i   (nvm_unlock_wr),
    .unlock_data_i (req_wdata_i[7:0]),
    .erase_wr_i    (nvm_erase_wr),
    .data_wr_i     (nvm_data_wr),
    .data_rd_i     (nvm_data_rd),
    .wdata_i       (req_wdata_i),
    .rdata_o       (nvm_rdata),
    .unlocked_o    (nvm_unlocked),
    .refused_o     (nvm_refused)
  );

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb
  begin
    logic [7:0] cml_set;
    logic [3:0] bidx;
    logic [2:0] tch;
    cml_set = 8'h00;
    bidx = 4'h0;
    tch = 3'h0;
    next_s = s;
    next_s.rsp_valid = req_i;
    next_s.fpin_meta = shared_fault_pin_in_i;
    next_s.fpin_sync = s.fpin_meta;
    if (wr_req)
    begin
      next_s.rsp_data = 16'h0000;
      case (eff_code)
        CMD_CH_CONFIG, CMD_FAULT_PROP0, CMD_FAULT_PROP1, CMD_SCRATCH_PAGED, CMD_TOOL_USER_B:
        begin
          if (!page_ok)
          begin
            cml_set[CML_BAD_DATA] = 1'b1;
          end
          for (int c = 0; c < NCH; c++)
          begin
            if (wr_hit[c])
            begin
              unique case (eff_code)
                CMD_CH_CONFIG:     next_s.ch_cfg[c] = req_wdata_i; // R12
                CMD_FAULT_PROP0:   next_s.prop0[c] = req_wdata_i[7:0]; // R14
                CMD_FAULT_PROP1:   next_s.prop1[c] = req_wdata_i[7:0]; // R15
                CMD_SCRATCH_PAGED: next_s.scr_p[c] = req_wdata_i; // R17
                CMD_TOOL_USER_B:   next_s.user_b[c] = req_wdata_i;
              endcase
            end
          end
        end
        CMD_GLOB_CONFIG:  next_s.glb_cfg = req_wdata_i; // R13
        CMD_PG_MAPPING:   next_s.pg_map = req_wdata_i; // R16
        CMD_SCRATCH_GLOB: next_s.scr_g = req_wdata_i; // R17
        CMD_TOOL_USER_A:  next_s.user_a = req_wdata_i;
        CMD_OEM_USER:     next_s.user_c = req_wdata_i;
        CMD_ALT_COMMAND:
        begin
          next_s.alt_cmd = req_wdata_i; // R10
          next_s.alt_ptr0 = 3'h0;
          next_s.alt_ptr1 = 3'h0;
        end
        CMD_COMM_STATUS, CMD_VENDOR_STATUS, CMD_VIN, CMD_VOUT, CMD_TEMP, CMD_REVISION,
        CMD_VENDOR_INFO, CMD_EXTRA_STATUS, CMD_TELEMETRY:
          cml_set[CML_BAD_DATA] = 1'b1; // R20
        CMD_NVM_UNLOCK, CMD_NVM_ERASE, CMD_NVM_DATA, CMD_RSVD_A, CMD_RSVD_B: ;
        default: cml_set[CML_BAD_CMD] = 1'b1;
      endcase
    end
    else if (rd_req)
    begin
      case (eff_code)
        CMD_COMM_STATUS:   next_s.rsp_data = {8'h00, s.cml}; // R1
        CMD_VENDOR_STATUS: next_s.rsp_data = {8'h00, vendor_status_i[rd_ch]}; // R2
        CMD_VIN:           next_s.rsp_data = vin_reading_i; // R3
        CMD_TEMP:          next_s.rsp_data = temp_reading_i; // R3
        CMD_VOUT:          next_s.rsp_data = vout_reading_i[rd_ch]; // R4
        CMD_REVISION:      next_s.rsp_data = {8'h00, REVISION_VALUE}; // R5
        CMD_TOOL_USER_A:   next_s.rsp_data = s.user_a;
        CMD_TOOL_USER_B:   next_s.rsp_data = s.user_b[rd_ch];
        CMD_OEM_USER:      next_s.rsp_data = s.user_c;
        CMD_SCRATCH_PAGED: next_s.rsp_data = s.scr_p[rd_ch]; // R17
        CMD_SCRATCH_GLOB:  next_s.rsp_data = s.scr_g; // R17
        CMD_VENDOR_INFO:   next_s.rsp_data = {12'h000, s.fpin_sync};
        CMD_EXTRA_STATUS:  next_s.rsp_data = extra_status_i[rd_ch]; // R6
        CMD_NVM_UNLOCK:    next_s.rsp_data = {15'h0000, nvm_unlocked};
        CMD_NVM_DATA:      next_s.rsp_data = nvm_rdata; // R9
        CMD_ALT_COMMAND:   next_s.rsp_data = s.alt_cmd;
        CMD_CH_CONFIG:     next_s.rsp_data = s.ch_cfg[rd_ch]; // R12
        CMD_GLOB_CONFIG:   next_s.rsp_data = s.glb_cfg; // R13
        CMD_FAULT_PROP0:   next_s.rsp_data = {8'h00, s.prop0[rd_ch]};
        CMD_FAULT_PROP1:   next_s.rsp_data = {8'h00, s.prop1[rd_ch]};
        CMD_PG_MAPPING:    next_s.rsp_data = s.pg_map;
        CMD_TELEMETRY:
        begin
          if (alt_access)
          begin
            // word-wise walk through the block, one pointer per host
            tch = alt_host1 ? s.alt_ptr1 : s.alt_ptr0; // R10
            next_s.rsp_data = vout_reading_i[tch];
            if (alt_host1)
            begin
              next_s.alt_ptr1 = s.alt_ptr1 + 3'h1;
            end
            else
            begin
              next_s.alt_ptr0 = s.alt_ptr0 + 3'h1;
            end
          end
          else if (blk_index_i == 5'h00)
          begin
            next_s.rsp_data = {8'h00, TLM_BYTE_COUNT}; // R11
          end
          else
          begin
            // byte n of block: channel (n-1)/2, low byte first
            bidx = 4'(blk_index_i - 5'h01);
            tch = bidx[3:1];
            next_s.rsp_data = {8'h00, bidx[0] ? vout_reading_i[tch][15:8] : vout_reading_i[tch][7:0]}; // R11
          end
        end
        CMD_NVM_ERASE, CMD_RSVD_A, CMD_RSVD_B: next_s.rsp_data = 16'h0000;
        default:
        begin
          next_s.rsp_data = 16'h0000;
          cml_set[CML_BAD_CMD] = 1'b1;
        end
      endcase
    end
    if (nvm_refused)
    begin
      cml_set[CML_MEM_FAULT] = 1'b1; // R7
    end
    // a new event outweighs a clear in the same cycle
    next_s.cml = (clear_faults_i ? 8'h00 : s.cml) | cml_set; // R1 R20
    // fault pins pulled low by faulted-off channels routed to them
    next_s.fpin_oe = 4'h0;
    for (int c = 0; c < NCH; c++)
    begin
      if (ch_faulted_off_i[c])
      begin
        next_s.fpin_oe[0] = next_s.fpin_oe[0] | s.prop0[c][PROP_LOW_PIN]; // R14
        next_s.fpin_oe[2] = next_s.fpin_oe[2] | s.prop0[c][PROP_HIGH_PIN]; // R14
        next_s.fpin_oe[1] = next_s.fpin_oe[1] | s.prop1[c][PROP_LOW_PIN]; // R15
        next_s.fpin_oe[3] = next_s.fpin_oe[3] | s.prop1[c][PROP_HIGH_PIN]; // R15
      end
    end
    // power good needs every selected channel and, if chosen, the watchdog
    next_s.pg_out = (&(ch_power_good_i | ~s.pg_map[NCH-1:0]))
                    && (!s.pg_map[PG_WDOG_BIT] || watchdog_ok_i); // R16
  end

  // ----------------------------------------------------------------
  // state register
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      s <= '{cml: 8'h00, alt_cmd: 16'h0000, alt_ptr0: 3'h0, alt_ptr1: 3'h0,
             ch_cfg: {NCH{CH_CONFIG_RST}}, glb_cfg: GLOB_CONFIG_RST,
             prop0: {NCH{FAULT_PROP_RST}}, prop1: {NCH{FAULT_PROP_RST}},
             pg_map: PG_MAPPING_RST, scr_p: {NCH{SCRATCH_RST}}, scr_g: SCRATCH_RST,
             user_a: USER_WORD_RST, user_b: {NCH{USER_WORD_RST}}, user_c: USER_WORD_RST,
             rsp_valid: 1'b0, rsp_data: 16'h0000, fpin_meta: 4'h0, fpin_sync: 4'h0,
             fpin_oe: 4'h0, pg_out: 1'b0};
    end
    else
    begin
      s <= next_s;
    end
  end

  // outputs
  assign rsp_valid_o            = s.rsp_valid;
  assign rsp_data_o             = s.rsp_data;
  assign shared_fault_pin_oe_o  = s.fpin_oe;
  assign shared_fault_pin_out_o = 4'h0;
  assign power_good_output_o    = s.pg_out;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  sequence ro_write_s;
    wr_req && !alt_access && (req_code_i == CMD_VIN || req_code_i == CMD_REVISION);
  endsequence

  sequence flag_seen_s;
    s.cml[CML_BAD_DATA] ##0 (s.rsp_valid && s.rsp_data == 16'h0000);
  endsequence

  chk_rev_value: assert property (@(posedge clk_i) disable iff (!arst_n_i) // R5
    (rd_req && !alt_access && req_code_i == CMD_REVISION) |=> rsp_valid_o && rsp_data_o == 16'h0011)
    else $error("revision read wrong");

  chk_ro_write_flag: assert property (@(posedge clk_i) disable iff (!arst_n_i) // R20
    ro_write_s |=> flag_seen_s)
    else $error("read-only write not flagged");

  chk_vout_page: assert property (@(posedge clk_i) disable iff (!arst_n_i) // R4
    (rd_req && !alt_access && req_code_i == CMD_VOUT && page_i == 8'h03)
      |=> rsp_data_o == $past(vout_reading_i[3]))
    else $error("output voltage read used wrong page");

  chk_glob_mask: assert property (@(posedge clk_i) disable iff (!arst_n_i) // R18
    (wr_req && !alt_access && req_code_i == CMD_FAULT_PROP0 && page_i == PAGE_GLOBAL
      && !global_page_channel_mask_i[1]) |=> s.prop0[1] == $past(s.prop0[1]))
    else $error("masked channel written by global page");

  chk_unpaged_cfg: assert property (@(posedge clk_i) disable iff (!arst_n_i) // R13
    (wr_req && !alt_access && req_code_i == CMD_GLOB_CONFIG) |=> s.glb_cfg == $past(req_wdata_i))
    else $error("global configuration not stored");

  chk_pg_pin: assert property (@(posedge clk_i) disable iff (!arst_n_i) // R16
    ((|(s.pg_map[NCH-1:0] & ~ch_power_good_i)) || (s.pg_map[PG_WDOG_BIT] && !watchdog_ok_i))
      |=> !power_good_output_o)
    else $error("power good ignored selected channel");

  chk_fault_route: assert property (@(posedge clk_i) disable iff (!arst_n_i) // R14
    (s.prop0[0][PROP_LOW_PIN] && ch_faulted_off_i[0]) |=> shared_fault_pin_oe_o[0])
    else $error("faulted channel not routed to pin");

  chk_tlm_count: assert property (@(posedge clk_i) disable iff (!arst_n_i) // R11
    (rd_req && !alt_access && req_code_i == CMD_TELEMETRY && blk_index_i == 5'h00)
      |=> rsp_data_o == 16'h0010)
    else $error("telemetry byte count wrong");

  chk_rsp_timing: assert property (@(posedge clk_i) disable iff (!arst_n_i) // answer valid one cycle after each request
    req_i |=> rsp_valid_o ##1 (rsp_valid_o == $past(req_i)))
    else $error("answer not one cycle after request");

endmodule

// ==== tb/pmsc_host_model.sv ====
`timescale 1ns/100ps
module pmsc_host_model
(
  input  wire logic        clk_i,
  input  wire logic        rsp_valid_i,
  input  wire logic [15:0] rsp_data_i,
  output logic             req_o = 1'b0,
  output logic             wr_o = 1'b0,
  output logic [7:0]       code_o = 8'h00,
  output logic [15:0]      wdata_o = 16'h0000
);
  // request off a falling edge, answer taken at the next falling edge, half a cycle after the taking edge
  task automatic xfer(logic w, logic [7:0] c, logic [15:0] d, output logic [15:0] r);
    @(negedge clk_i);
    req_o = 1'b1;
    wr_o = w;
    code_o = c;
    wdata_o = d;
    @(negedge clk_i);
    r = rsp_valid_i ? rsp_data_i : 16'hdead;
    req_o = 1'b0;
    wdata_o = ~d; // idle data never repeats the last word
  endtask
endmodule

// ==== tb/pmsc_cmd_map_tb.sv ====
`timescale 1ns/100ps
module pmsc_cmd_map_tb;
  import pmsc_pkg::*;
  logic                 clk = 1'b0, arst_n = 1'b0, wdog = 1'b0, req, wr, pg_out, rsp_valid, clr = 1'b0;
  logic [4:0]           blk = 5'h00;
  logic [7:0]           code, page = 8'h00, mask = 8'hff, foff = 8'h00;
  logic [15:0]          wdata, rd, rsp_data;
  logic [3:0]           oe, fout;
  logic [NCH-1:0][15:0] vout;
  int                   fail_count = 0, checks = 0;
  // distinct reading per channel so a wrong page shows up
  assign vout = 128'h1777_1666_1555_1444_1333_1222_1111_1000;
  pmsc_cmd_map i_dut (.clk_i(clk), .arst_n_i(arst_n), .req_i(req), .req_write_i(wr), .req_code_i(code),
    .req_wdata_i(wdata), .blk_index_i(blk), .page_i(page), .global_page_channel_mask_i(mask),
    .clear_faults_i(clr), .vin_reading_i(16'h4321), .temp_reading_i(16'h8765), .vout_reading_i(vout),
    .vendor_status_i(64'h8877_6655_4433_2211), .extra_status_i(vout), .ch_faulted_off_i(foff),
    .ch_power_good_i(~foff), .watchdog_ok_i(wdog), .shared_fault_pin_in_i(~oe), .shared_fault_pin_out_o(fout),
    .shared_fault_pin_oe_o(oe), .power_good_output_o(pg_out), .rsp_valid_o(rsp_valid), .rsp_data_o(rsp_data));
  pmsc_host_model i_host (.clk_i(clk), .rsp_valid_i(rsp_valid), .rsp_data_i(rsp_data), .req_o(req), .wr_o(wr),
    .code_o(code), .wdata_o(wdata));
  // free-running bench clock, 40 ns period
  initial
    forever #20 clk = ~clk;
  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    checks++;
    fail_count += int'(seen !== exp);
    if (seen !== exp)
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
  endtask
  task automatic finish_test();
    $display("checks %0d mismatches %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  task automatic op(string what, logic w, logic [7:0] c, logic [15:0] d, logic [15:0] exp);
    i_host.xfer(w, c, d, rd);
    check(what, rd, exp);
  endtask
  task automatic t_regs();
    op("wr ro", 1'b1, 8'h98, 16'h0055, 16'h0000);
    op("rev", 1'b0, 8'h98, 16'h0000, 16'h0011);
    page = 8'h02;
    op("wr cfg", 1'b1, 8'hd0, 16'habcd, 16'h0000);
    page = 8'h03;
    op("cfg", 1'b0, 8'hd0, 16'h0000, 16'h0080);
    op("vout", 1'b0, 8'h8b, 16'h0000, vout[3]);
    op("tlm", 1'b0, 8'hcf, 16'h0000, 16'h0010);
  endtask
  task automatic t_nvm();
    op("wr lock", 1'b1, 8'hbe, 16'h0000, 16'h0000);
    op("cml", 1'b0, 8'h7e, 16'h0000, 16'h0050);
    op("unlock", 1'b1, 8'hbd, 16'h002b, 16'h0000);
    op("erase", 1'b1, 8'hbe, 16'h0000, 16'h0000);
    op("wr nvm", 1'b1, 8'hbf, 16'h1234, 16'h0000);
    op("rewind", 1'b1, 8'hbd, 16'h002b, 16'h0000);
    op("nvm0", 1'b0, 8'hbf, 16'h0000, 16'h1234);
    op("nvm1", 1'b0, 8'hbf, 16'h0000, 16'hffff);
    op("alt cmd", 1'b1, 8'hc0, 16'h00cf, 16'h0000);
    op("alt0", 1'b0, 8'hc1, 16'h0000, vout[0]);
    op("alt0 next", 1'b0, 8'hc1, 16'h0000, vout[1]);
  endtask
  task automatic t_more();
    clr = 1'b1;
    @(negedge clk);
    clr = 1'b0;
    op("cml clr", 1'b0, 8'h7e, 16'h0000, 16'h0000);
    op("vin", 1'b0, 8'h88, 16'h0000, 16'h4321);
    op("temp", 1'b0, 8'h8d, 16'h0000, 16'h8765);
    op("vendor", 1'b0, 8'h80, 16'h0000, 16'h0044);
    op("extra", 1'b0, 8'hb7, 16'h0000, vout[3]);
    op("gcfg rst", 1'b0, 8'hd1, 16'h0000, 16'h1c7b);
    op("wr gcfg", 1'b1, 8'hd1, 16'h1234, 16'h0000);
    page = 8'h05;
    op("gcfg", 1'b0, 8'hd1, 16'h0000, 16'h1234);
    op("wr scr", 1'b1, 8'hb3, 16'h5a5a, 16'h0000);
    op("scr", 1'b0, 8'hb3, 16'h0000, 16'h5a5a);
    op("wr scrg", 1'b1, 8'hb4, 16'ha5a5, 16'h0000);
    op("wr prop1", 1'b1, 8'hd3, 16'h0002, 16'h0000);
    op("prop1", 1'b0, 8'hd3, 16'h0000, 16'h0002);
    page = 8'h03;
    op("scr ch3", 1'b0, 8'hb3, 16'h0000, 16'h0000);
    op("scrg ch3", 1'b0, 8'hb4, 16'h0000, 16'ha5a5);
    blk = 5'h05;
    op("tlm lo", 1'b0, 8'hcf, 16'h0000, 16'h0022);
    blk = 5'h06;
    op("tlm hi", 1'b0, 8'hcf, 16'h0000, 16'h0012);
    blk = 5'h00;
  endtask
  task automatic t_pins();
    mask = 8'h01;
    page = 8'hff;
    op("wr prop", 1'b1, 8'hd2, 16'h0001, 16'h0000);
    foff = 8'h03;
    op("wr pg", 1'b1, 8'hd4, 16'h0180, 16'h0000);
    @(negedge clk);
    check("fault oe", {12'h000, oe}, 16'h0001);
    check("fault out", {12'h000, fout}, 16'h0000);
    check("pg wdog", {15'h0000, pg_out}, 16'h0000);
    wdog = 1'b1;
    repeat (2) @(negedge clk);
    check("pg ok", {15'h0000, pg_out}, 16'h0001);
    page = 8'h01;
    op("prop masked", 1'b0, 8'hd2, 16'h0000, 16'h0000);
  endtask
  // reset for eight cycles, then the scenarios and the verdict
  initial
  begin
    repeat (8) @(negedge clk);
    arst_n = 1'b1;
    t_regs();
    t_nvm();
    t_more();
    t_pins();
    finish_test();
  end
  // cycle ceiling so a lost answer cannot hang the run
  initial
  begin
    repeat (4000) @(posedge clk);
    fail_count++;
    finish_test();
  end
endmodule
